/* design/wwd_core_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface wwd_core_if;
	logic                         tick;
	logic                         useMid;
	logic                         runEn;
	logic                         clearCount;
	logic [wwd_pkg::PS_W-1:0]     periodSel;
	logic [wwd_pkg::WIN_W-1:0]    windowSel;
	logic [wwd_pkg::TOT_W-1:0]    count;
	logic                         timeout;
	logic                         windowOpen;

	modport gen (input useMid, output tick);
	modport core (input tick, runEn, clearCount, periodSel, windowSel,
		output count, timeout, windowOpen);
	modport ctrl (input count, timeout, windowOpen,
		output useMid, runEn, clearCount, periodSel, windowSel);
endinterface
`default_nettype wire

/* design/wwd_pkg.sv */
package wwd_pkg;

	// ==========================================
	// Register map, byte addresses
	localparam logic [3:0]  CTRL_ZERO_OFS  = 4'h0;
	localparam logic [3:0]  CTRL_ONE_OFS   = 4'h4;
	localparam logic [3:0]  STATUS_OFS     = 4'h8;
	localparam logic [3:0]  COUNT_OFS      = 4'hC;

	// ==========================================
	// Field positions
	localparam int          SWEN_BIT       = 0;
	localparam int          PSEL_LSB       = 1;
	localparam int          WIN_LSB        = 0;
	localparam int          SRC_LSB        = 4;
	localparam int          ST_VIOL_N      = 0;
	localparam int          ST_WDRST       = 1;
	localparam int          ST_TO_N        = 2;
	localparam int          ST_PD_N        = 3;
	localparam int          ST_ARMED       = 4;
	localparam int          ST_RUN         = 5;

	// ==========================================
	// Widths and codes
	localparam int          PS_W           = 5;
	localparam int          WIN_W          = 3;
	localparam int          SRC_W          = 3;
	localparam int          PRE_W          = 18;
	localparam int          CNT_W          = 5;
	localparam int          TOT_W          = PRE_W + CNT_W;
	localparam logic [4:0]  PS_MIN_SHIFT   = 5'h05;
	localparam logic [4:0]  PS_MAX_CODE    = 5'h12;
	localparam logic [4:0]  PS_MIN_CODE    = 5'h00;
	localparam logic [4:0]  PS_SW_CODE     = 5'h1F;
	localparam logic [4:0]  PS_DEFAULT     = 5'h0B;
	localparam logic [4:0]  WIN_FRAC_SHIFT = 5'h02;
	localparam logic [2:0]  WIN_SW_CODE    = 3'h7;
	localparam logic [2:0]  WIN_OPEN_ALL   = 3'h7;
	localparam logic [2:0]  SRC_SW_CODE    = 3'h7;
	localparam logic [2:0]  SRC_LOW        = 3'h0;
	localparam logic [2:0]  SRC_MID        = 3'h1;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_SW     = 2'b01,
		MODE_AWAKE  = 2'b10,
		MODE_ALWAYS = 2'b11
	} wwd_mode_e;

endpackage

/* design/wwd_tick_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module wwd_tick_gen #(
	parameter int NUM_SRC = 2
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// Oscillator pins
	input  wire logic [NUM_SRC-1:0] oscIn,
	// Tick to the timer
	wwd_core_if.gen                 tickBus
);
	logic [NUM_SRC-1:0] meta_q;
	logic [NUM_SRC-1:0] sync_q;
	logic [NUM_SRC-1:0] last_q;
	logic [NUM_SRC-1:0] rise;
	logic               tick_q;
	wire                selRise;

	// ==========================================
	// Two-stage synchroniser per source
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gSrc
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					meta_q[g] <= 1'b0;
					sync_q[g] <= 1'b0;
					last_q[g] <= 1'b0;
				end else begin
					meta_q[g] <= oscIn[g];
					sync_q[g] <= meta_q[g];
					last_q[g] <= sync_q[g];
				end
			end
			assign rise[g] = sync_q[g] & ~last_q[g];
		end
	endgenerate

	// Switching source mid-period may cost or add one tick only
	assign selRise = tickBus.useMid ? rise[1] : rise[0];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= selRise;
		end
	end

	assign tickBus.tick = tick_q;
endmodule
`default_nettype wire

/* design/wwd_timer_core.sv */
`timescale 1ns/10ps
`default_nettype none
module wwd_timer_core (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Control and results
	wwd_core_if.core  tmr
);
	logic [wwd_pkg::TOT_W-1:0] count_q;
	logic [wwd_pkg::TOT_W-1:0] count_d;
	logic                      timeout_q;
	logic                      timeout_d;
	wire  [wwd_pkg::PS_W-1:0]  psEff;
	wire  [4:0]                periodBits;
	wire  [wwd_pkg::TOT_W-1:0] periodMax;
	wire  [wwd_pkg::TOT_W-1:0] elapsedWide;
	wire  [2:0]                elapsed;
	wire  [2:0]                closedIdx;
	wire                       atEnd;

	// ==========================================
	// Period decode
	assign psEff = (tmr.periodSel > wwd_pkg::PS_MAX_CODE) ? wwd_pkg::PS_MIN_CODE
		: tmr.periodSel;
	assign periodBits = psEff + wwd_pkg::PS_MIN_SHIFT;
	assign periodMax = {wwd_pkg::TOT_W{1'b1}} >> (5'(wwd_pkg::TOT_W) - periodBits);
	assign atEnd = (count_q == periodMax);

	// ==========================================
	// Window: top three bits of elapsed time against closed eighths
	assign elapsedWide = count_q >> (psEff + wwd_pkg::WIN_FRAC_SHIFT);
	assign elapsed = elapsedWide[2:0];
	assign closedIdx = wwd_pkg::WIN_OPEN_ALL - tmr.windowSel;
	assign tmr.windowOpen = (elapsed >= closedIdx);

	// ==========================================
	// Prescaler and counter as one chain
	always_comb begin
		count_d = count_q;
		timeout_d = 1'b0;
		if (tmr.clearCount || !tmr.runEn) begin
			count_d = '0;
		end else if (tmr.tick) begin
			if (atEnd) begin
				count_d = '0;
				timeout_d = 1'b1;
			end else begin
				count_d = count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_q <= '0;
			timeout_q <= 1'b0;
		end else begin
			count_q <= count_d;
			timeout_q <= timeout_d;
		end
	end

	assign tmr.count = count_q;
	assign tmr.timeout = timeout_q;
endmodule
`default_nettype wire

/* design/wwd_windowed_watchdog.sv */
// What this block does
// - Mode 11 keeps the watchdog running always, Sleep included, ignoring enable.
// - Mode 10 runs the watchdog awake and stops it in Sleep.
// - Mode 01 runs only while the software enable is 1; enable resets 0.
// - Mode 00 keeps the watchdog off whatever enable or Sleep say.
// - A running watchdog reaching its period uncleared requests a system reset.
// - Prescale code 0 divides by 32, each step doubles to 10010; above is 32.
// - Reset loads prescale from configuration, or 01011 when configuration is 11111.
// - Prescale is read-only unless the configuration prescale is 11111.
// - Tick comes from low or mid oscillator, chosen by configuration or software.
// - Window size comes from configuration, or software when configuration is 111.
// - In windowed mode a clear while the window is closed resets like a time-out.
// - A violation clears the low-active violation flag; reset or software sets it.
// - Count clears on reset, clear, Sleep in/out, disable, start-up timer, control writes.
// - Windowed mode needs a control-zero read to arm; unarmed clear is a violation.
// - Time-out in Sleep wakes instead of reset and updates status flags.
// - Sleep entry clears then counts on; after exit count holds while start-up runs.
// - Changing the oscillator divider leaves the count alone.
// - Window code 000 closes 87.5 percent, each step 12.5 less, 111 all open.
// - Reset loads the software window field from the configuration window.
// - Software clock code 001 picks mid, 000 picks low; others reserved.
// - A readable armed bit shows 1 while armed.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module wwd_windowed_watchdog (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [3:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// Configuration word
	input  wire logic [1:0]                wdModeCfg,
	input  wire logic [wwd_pkg::PS_W-1:0]  cfgTimeoutPrescale,
	input  wire logic [wwd_pkg::WIN_W-1:0] cfgOpenSpan,
	input  wire logic [wwd_pkg::SRC_W-1:0] cfgTickSource,
	// Oscillator pins
	input  wire logic                      lowFreqOsc,
	input  wire logic                      midFreqOsc,
	// Core events
	input  wire logic                      wdClearInstr,
	input  wire logic                      sleepActive,
	input  wire logic                      oscStartupTimer,
	// Results
	output logic                           wdResetReq,
	output logic                           wdWakeReq,
	output logic                           violationFlag_n,
	output logic                           wdResetFlag,
	output logic                           timeoutStatus_n,
	output logic                           powerdownStatus_n,
	output logic                           wdArmed
);
	// ==========================================
	// Registers
	logic [wwd_pkg::PS_W-1:0]  timeoutPrescaleSel_q;
	logic                      swEnableBit_q;
	logic [wwd_pkg::SRC_W-1:0] tickSourceSel_q;
	logic [wwd_pkg::WIN_W-1:0] openSpanSel_q;
	logic                      armed_q;
	logic                      violN_q;
	logic                      wdRstFlag_q;
	logic                      toN_q;
	logic                      pdN_q;
	logic                      sleep_q;
	logic                      resetReq_q;
	logic                      wakeReq_q;
	logic                      ack_q;
	logic [31:0]               rdData_q;

	wwd_core_if coreBus ();

	// ==========================================
	// Bus decode
	wire        busReq    = wb_cyc_i & wb_stb_i;
	wire        busDone   = busReq & ack_q;
	wire        wrDone    = busDone & wb_we_i;
	wire        rdDone    = busDone & ~wb_we_i;
	wire        hitCtrl0  = (wb_adr_i == wwd_pkg::CTRL_ZERO_OFS);
	wire        hitCtrl1  = (wb_adr_i == wwd_pkg::CTRL_ONE_OFS);
	wire        hitStatus = (wb_adr_i == wwd_pkg::STATUS_OFS);
	wire        hitCount  = (wb_adr_i == wwd_pkg::COUNT_OFS);
	wire        wrCtrl0   = wrDone & hitCtrl0 & wb_sel_i[0];
	wire        wrCtrl1   = wrDone & hitCtrl1 & wb_sel_i[0];
	wire        wrStatus  = wrDone & hitStatus & wb_sel_i[0];
	wire        rdCtrl0   = rdDone & hitCtrl0;

	// ==========================================
	// Software-visible selects
	wire        psWritable  = (cfgTimeoutPrescale == wwd_pkg::PS_SW_CODE);
	wire        srcWritable = (cfgTickSource == wwd_pkg::SRC_SW_CODE);
	wire        winWritable = (cfgOpenSpan == wwd_pkg::WIN_SW_CODE);
	wire [wwd_pkg::PS_W-1:0]  psResetVal  = psWritable ? wwd_pkg::PS_DEFAULT
		: cfgTimeoutPrescale;
	wire [wwd_pkg::SRC_W-1:0] srcResetVal = srcWritable ? wwd_pkg::SRC_LOW : cfgTickSource;
	wire [wwd_pkg::SRC_W-1:0] srcEff      = srcWritable ? tickSourceSel_q
		: cfgTickSource;
	wire [wwd_pkg::WIN_W-1:0] winEff      = winWritable ? openSpanSel_q
		: cfgOpenSpan;
	wire [wwd_pkg::PS_W-1:0]  psWrVal     = wb_dat_i[wwd_pkg::PSEL_LSB +: wwd_pkg::PS_W];
	wire [wwd_pkg::SRC_W-1:0] srcWrVal    = wb_dat_i[wwd_pkg::SRC_LSB +: wwd_pkg::SRC_W];
	wire [wwd_pkg::WIN_W-1:0] winWrVal    = wb_dat_i[wwd_pkg::WIN_LSB +: wwd_pkg::WIN_W];

	// ==========================================
	// Enable by mode
	wire        modeAlways = (wdModeCfg == wwd_pkg::MODE_ALWAYS);
	wire        modeAwake  = (wdModeCfg == wwd_pkg::MODE_AWAKE);
	wire        modeSw     = (wdModeCfg == wwd_pkg::MODE_SW);
	wire        runEnable  = modeAlways
		| (modeAwake & ~sleepActive)
		| (modeSw & swEnableBit_q);
	// Mode 00 falls through every term above, so it never runs

	// ==========================================
	// Clearing events
	wire        windowed    = (winEff != wwd_pkg::WIN_OPEN_ALL);
	wire        clrSeen     = wdClearInstr & runEnable & ~sleepActive;
	wire        clrBad      = clrSeen & windowed
		& (~armed_q | ~coreBus.windowOpen);
	wire        clrGood     = clrSeen & ~clrBad;
	wire        sleepEdge   = sleepActive ^ sleep_q;
	// Divider changes in the oscillator are not an input here
	wire        clearNow    = clrGood | sleepEdge | oscStartupTimer
		| wrCtrl0 | wrCtrl1;
	wire        timeoutAwk  = coreBus.timeout & ~sleepActive;
	wire        timeoutSlp  = coreBus.timeout & sleepActive;

	assign coreBus.useMid     = (srcEff == wwd_pkg::SRC_MID);
	assign coreBus.runEn      = runEnable;
	assign coreBus.clearCount = clearNow;
	assign coreBus.periodSel  = timeoutPrescaleSel_q;
	assign coreBus.windowSel  = winEff;

	// ==========================================
	// Submodules
	wwd_tick_gen #(
		.NUM_SRC (2)
	) uTick (
		.ref_clk (ref_clk),
		.rst     (rst),
		.oscIn   ({midFreqOsc, lowFreqOsc}),
		.tickBus (coreBus)
	);

	wwd_timer_core uCore (
		.ref_clk (ref_clk),
		.rst     (rst),
		.tmr     (coreBus)
	);

	// ==========================================
	// Control registers; write lands at the ack edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			timeoutPrescaleSel_q <= psResetVal;
			swEnableBit_q <= 1'b0;
			tickSourceSel_q <= srcResetVal;
			openSpanSel_q <= cfgOpenSpan;
		end else begin
			if (wrCtrl0) begin
				swEnableBit_q <= wb_dat_i[wwd_pkg::SWEN_BIT];
				if (psWritable) begin
					timeoutPrescaleSel_q <= psWrVal;
				end
			end
			if (wrCtrl1 && srcWritable) begin
				tickSourceSel_q <= srcWrVal;
			end
			if (wrCtrl1 && winWritable) begin
				openSpanSel_q <= winWrVal;
			end
		end
	end

	// ==========================================
	// Arming; a clear consumes it, a fresh read re-arms
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (rdCtrl0) begin
			armed_q <= 1'b1;
		end else if (clrSeen || wrCtrl0 || wrCtrl1) begin
			armed_q <= 1'b0;
		end
	end

	// ==========================================
	// Status flags; hardware events win over software
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			violN_q <= 1'b1;
			wdRstFlag_q <= 1'b0;
			toN_q <= 1'b1;
			pdN_q <= 1'b1;
		end else begin
			if (clrBad) begin
				violN_q <= 1'b0;
			end else if (wrStatus && wb_dat_i[wwd_pkg::ST_VIOL_N]) begin
				violN_q <= 1'b1;
			end
			if (coreBus.timeout || clrBad) begin
				wdRstFlag_q <= 1'b1;
			end else if (wrStatus && wb_dat_i[wwd_pkg::ST_WDRST]) begin
				wdRstFlag_q <= 1'b0;
			end
			if (coreBus.timeout) begin
				toN_q <= 1'b0;
			end else if (wrStatus && wb_dat_i[wwd_pkg::ST_TO_N]) begin
				toN_q <= 1'b1;
			end
			if (timeoutSlp) begin
				pdN_q <= 1'b0;
			end else if (wrStatus && wb_dat_i[wwd_pkg::ST_PD_N]) begin
				pdN_q <= 1'b1;
			end
		end
	end

	// ==========================================
	// Reset and wake requests, one-cycle pulses
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			resetReq_q <= 1'b0;
			wakeReq_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			resetReq_q <= timeoutAwk | clrBad;
			wakeReq_q <= timeoutSlp;
			sleep_q <= sleepActive;
		end
	end

	// ==========================================
	// Read mux; unmapped words read zero but still ack
	wire [31:0] rdCtrl0Val = {26'h0, timeoutPrescaleSel_q, swEnableBit_q};
	wire [31:0] rdCtrl1Val = {25'h0, srcEff, 1'b0, winEff};
	wire [31:0] rdStatVal  = {26'h0, runEnable, armed_q, pdN_q, toN_q,
		wdRstFlag_q, violN_q};
	wire [31:0] rdCountVal = {{(32 - wwd_pkg::TOT_W){1'b0}}, coreBus.count};
	wire [31:0] rdMux      = hitCtrl0 ? rdCtrl0Val
		: hitCtrl1 ? rdCtrl1Val
		: hitStatus ? rdStatVal
		: hitCount ? rdCountVal
		: 32'h00000000;

	// Ack one cycle after request, dropped the cycle after
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			rdData_q <= 32'h00000000;
		end else begin
			ack_q <= busReq & ~ack_q;
			if (busReq && !ack_q) begin
				rdData_q <= rdMux;
			end
		end
	end

	assign wb_ack_o          = ack_q;
	assign wb_dat_o          = rdData_q;
	assign wdResetReq        = resetReq_q;
	assign wdWakeReq         = wakeReq_q;
	assign violationFlag_n   = violN_q;
	assign wdResetFlag       = wdRstFlag_q;
	assign timeoutStatus_n   = toN_q;
	assign powerdownStatus_n = pdN_q;
	assign wdArmed           = armed_q;
endmodule
`default_nettype wire

/* verif/wwd_windowed_watchdog_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker
module wwd_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	// Events and results
	input wire logic [1:0]  wdModeCfg,
	input wire logic        sleepActive,
	input wire logic        wdResetReq,
	input wire logic        wdWakeReq,
	input wire logic        violationFlag_n,
	input wire logic        wdResetFlag,
	input wire logic        timeoutStatus_n,
	input wire logic        powerdownStatus_n,
	input wire logic        wdArmed
);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// ==========================================
	// Sequences
	// Three cycles of one state: the request lags the level by one cycle
	sequence s_asleep;
		sleepActive [*3];
	endsequence
	sequence s_awake;
		!sleepActive [*3];
	endsequence
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_arm;
		wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
	endsequence
	// ==========================================
	// Assertions
	a_bus_answer: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_off_silent: assert property (wdModeCfg == 2'h0 |-> !wdResetReq && !wdWakeReq)
		else $error("off mode acted");
	a_sleep_noreset: assert property (s_asleep |-> !wdResetReq)
		else $error("reset in sleep");
	a_awake_nowake: assert property (s_awake |-> !wdWakeReq)
		else $error("wake while awake");
	a_viol_resets: assert property ($fell(violationFlag_n) |-> wdResetReq)
		else $error("violation without reset");
	a_viol_set: assert property ($rose(violationFlag_n) |->
		$past(rst || (wb_ack_o && wb_we_i && wb_adr_i == 4'h8 && wb_dat_i[0])))
		else $error("violation flag set by itself");
	a_reset_flags: assert property (wdResetReq |=> wdResetFlag)
		else $error("reset flag");
	// Violation leaves the time-out bit alone, so only a reset with the flag high counts
	a_timeout_flag: assert property (wdResetReq && violationFlag_n |=> !timeoutStatus_n)
		else $error("time-out flag");
	a_wake_flags: assert property (wdWakeReq |=> !powerdownStatus_n && wdResetFlag)
		else $error("wake flags");
	a_read_arms: assert property (s_arm |=> wdArmed)
		else $error("read did not arm");
	a_reset_state: assert property (disable iff (1'b0) rst |=> !wb_ack_o &&
		violationFlag_n && !wdResetFlag && timeoutStatus_n && !wdArmed && !wdResetReq)
		else $error("reset state");
endmodule
bind wwd_windowed_watchdog wwd_props u_props (.ref_clk(ref_clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wdModeCfg(wdModeCfg),
	.sleepActive(sleepActive), .wdResetReq(wdResetReq), .wdWakeReq(wdWakeReq),
	.violationFlag_n(violationFlag_n), .wdResetFlag(wdResetFlag),
	.timeoutStatus_n(timeoutStatus_n), .powerdownStatus_n(powerdownStatus_n),
	.wdArmed(wdArmed));
`default_nettype wire

/* verif/wwd_windowed_watchdog_test.sv */
`timescale 1ns/10ps
`default_nettype none
module wwd_windowed_watchdog_test;
	// ==========================================
	// Signals
	logic        ref_clk, rst, wbCyc, wbStb, wbWe, ack;
	logic [3:0]  wbAdr;
	logic [31:0] wbDat, rdDat, q, r;
	logic [12:0] cfg;
	logic        lowOsc, midOsc, lowOn, midOn, clr, sleep, osc_startup_timer;
	logic        rstReq, wakeReq, violN, rstFlag, toN, pdN, armed;
	logic [2:0]  ph;
	logic [31:0] rows [4];
	int          numErrors, compares, nRst, nWake, cycles, b, w;

	wwd_windowed_watchdog dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
		.wb_dat_i(wbDat), .wb_dat_o(rdDat), .wb_ack_o(ack), .wdModeCfg(cfg[12:11]),
		.cfgTimeoutPrescale(cfg[10:6]), .cfgOpenSpan(cfg[5:3]), .cfgTickSource(cfg[2:0]),
		.lowFreqOsc(lowOsc), .midFreqOsc(midOsc), .wdClearInstr(clr), .sleepActive(sleep),
		.oscStartupTimer(osc_startup_timer), .wdResetReq(rstReq), .wdWakeReq(wakeReq),
		.violationFlag_n(violN), .wdResetFlag(rstFlag), .timeoutStatus_n(toN),
		.powerdownStatus_n(pdN), .wdArmed(armed));

	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ==========================================
	// Oscillators at one eighth of the clock, so code zero spans 256 cycles
	always @(posedge ref_clk) begin
		ph <= ph + 3'h1;
		lowOsc <= lowOn & ph[2];
		midOsc <= midOn & ph[2];
		nRst <= nRst + int'(rstReq === 1'h1);
		nWake <= nWake + int'(wakeReq === 1'h1);
		cycles <= cycles + 1;
		if (cycles > 9000) begin
			numErrors++;
			summarize();
		end
	end

	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe <= we;
		wbAdr <= a;
		wbDat <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'h1);
		q = rdDat;
		// Answer is fixed one cycle after the request is seen
		chk(32'(n), 32'h2, "ack latency");
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		wb(1'h0, a, 32'h0);
		chk(q, exp, what);
	endtask

	task automatic boot(input logic [12:0] c);
		@(posedge ref_clk);
		rst <= 1'h1;
		cfg <= c;
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		b = nRst;
		w = nWake;
	endtask

	task automatic pulse();
		@(posedge ref_clk);
		clr <= 1'h1;
		@(posedge ref_clk);
		clr <= 1'h0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic resets(input int eRst, input int eWake);
		chk(32'(nRst - b), 32'(eRst), "resets");
		chk(32'(nWake - w), 32'(eWake), "wakes");
	endtask

	task automatic summarize();
		$display("Checks %0d, errors %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Sequence: {mode, cfg prescale, cfg window, cfg source, ctrl0, ctrl1}
	initial begin
		{rst, wbCyc, wbStb, wbWe, wbAdr, wbDat, cfg} = {1'h1, 52'h0};
		{lowOsc, midOsc, lowOn, midOn, clr, sleep, osc_startup_timer, ph} = 10'h0;
		{numErrors, compares, nRst, nWake, cycles, b, w} = '0;
		rows[0] = {3'h0, 2'h3, 5'h1F, 3'h7, 3'h7, 8'h16, 8'h07};
		rows[1] = {3'h0, 2'h2, 5'h03, 3'h2, 3'h1, 8'h06, 8'h12};
		rows[2] = {3'h0, 2'h1, 5'h00, 3'h5, 3'h0, 8'h00, 8'h05};
		rows[3] = {3'h0, 2'h0, 5'h12, 3'h7, 3'h7, 8'h24, 8'h07};
		for (int i = 0; i < 4; i++) begin
			r = rows[i];
			boot(r[28:16]);
			rd(4'h8, {26'h0, r[28], 5'h0D}, "status");
			rd(4'h0, {24'h0, r[15:8]}, "control zero");
			rd(4'h4, {24'h0, r[7:0]}, "control one");
			wb(1'h1, 4'h0, 32'h0F);
			rd(4'h8, {26'h0, r[28] | (r[28:27] == 2'h1), 5'h0D}, "status");
			rd(4'h0, r[26:22] == 5'h1F ? 32'h0F : {24'h0, r[15:8] | 8'h01}, "prescale");
			rd(4'h2, 32'h0, "unmapped");
		end
		// Start-up hold, then the code-zero time-out lands 240 to 300 cycles after a clear
		boot({2'h3, 5'h00, 3'h7, 3'h0});
		lowOn <= 1'h1;
		osc_startup_timer <= 1'h1;
		idle(400);
		resets(0, 0);
		osc_startup_timer <= 1'h0;
		pulse();
		idle(240);
		resets(0, 0);
		idle(60);
		resets(1, 0);
		chk(32'({rstFlag, toN}), 32'h2, "time-out flags");
		// Tick source by software
		boot({2'h3, 5'h00, 3'h7, 3'h7});
		lowOn <= 1'h0;
		midOn <= 1'h1;
		idle(300);
		resets(0, 0);
		wb(1'h1, 4'h4, 32'h17);
		idle(300);
		resets(1, 0);
		sleep <= 1'h1;
		b = nRst;
		w = nWake;
		idle(300);
		resets(0, 1);
		chk(32'(pdN), 32'h0, "power-down flag");
		sleep <= 1'h0;
		boot({2'h2, 5'h00, 3'h7, 3'h1});
		sleep <= 1'h1;
		idle(600);
		resets(0, 0);
		sleep <= 1'h0;
		idle(300);
		resets(1, 0);
		// Window at half the period
		boot({2'h3, 5'h00, 3'h3, 3'h0});
		midOn <= 1'h0;
		lowOn <= 1'h1;
		pulse();
		idle(3);
		resets(1, 0);
		chk(32'(violN), 32'h0, "violation flag");
		wb(1'h1, 4'h8, 32'h01);
		idle(1);
		chk(32'(violN), 32'h1, "violation flag");
		wb(1'h1, 4'h0, 32'h0);
		wb(1'h0, 4'h0, 32'h0);
		idle(1);
		chk(32'(armed), 32'h1, "armed");
		idle(170);
		pulse();
		idle(3);
		resets(1, 0);
		chk(32'(armed), 32'h0, "armed");
		// Armed but early in the period: the closed window still trips
		wb(1'h0, 4'h0, 32'h0);
		pulse();
		idle(3);
		resets(2, 0);
		chk(32'(violN), 32'h0, "violation flag");
		summarize();
	end
endmodule
`default_nettype wire
